// *** rtl/event_flag_interrupt_unit.sv ***
// Event flag interrupt unit: flags, enables and open-drain alert
//
// Operation
// - Alert pin is open-drain, active low, pulls low only, never high.
// - Ten status bits sit in two status registers at 0x06 and 0x07.
// - Every status bit has its own enable bit at 0x04 and 0x05.
// - Enabled flag latches on source rising edge and asserts the alert.
// - Disabled flag reads the live source and never drives the alert.
// - Writing one to a status bit clears its latched event.
// - Hardware or software reset clears every latched event.
// - Sources are internal device conditions such as lock or warning.
`timescale 1ns/10ps
`default_nettype none
module event_flag_interrupt_unit (
   input wire logic sys_clk, // System clock, 40 MHz
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic soft_reset, // Software reset pulse
   input wire logic [9:0] event_source, // Internal event sources
   input wire logic reg_write, // Register write strobe
   input wire logic reg_read, // Register read strobe
   input wire logic [7:0] reg_addr, // Register offset
   input wire logic [7:0] reg_wdata, // Register write data
   output logic [7:0] reg_rdata, // Register read data
   output logic irq_pin_o, // Alert pin output level
   output logic irq_pin_oe // Alert pin output enable
);
   logic [9:0] enable_q;
   logic [9:0] live;
   logic [9:0] rise;
   logic [9:0] latched;
   logic [9:0] clear;
   logic [9:0] status;
   logic [7:0] rdata_q;
   logic irq_oe_q;
   logic irq_o_q;
   logic [9:0] armed;
   logic [9:0] pending;

   // ************************************************************
   // Status byte clears
   // ************************************************************
   function automatic logic hit(input logic [7:0] addr,
                                input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   assign clear[7:0] = (reg_write &&
      hit(reg_addr, event_flag_pkg::EVENT_STATUS_LOW_OFS)) ?
      reg_wdata : 8'h00;
   assign clear[9:8] = (reg_write &&
      hit(reg_addr, event_flag_pkg::EVENT_STATUS_HIGH_OFS)) ?
      reg_wdata[1:0] : 2'h0;

   // ************************************************************
   // Flag cells
   // ************************************************************
   for (genvar i = 0; i < event_flag_pkg::FLAG_COUNT; i++) begin : g_flag
      event_flag_cell u_cell (
         .sys_clk(sys_clk),
         .rst_n(rst_n),
         .source(event_source[i]),
         .enable(enable_q[i]),
         .clear(clear[i]),
         .soft_reset(soft_reset),
         .live(live[i]),
         .rise(rise[i]),
         .latched(latched[i])
      );
   end

   // Latch is hidden while disabled so software can watch the source
   assign status = (enable_q & latched) | (~enable_q & live);

   // ************************************************************
   // Enable registers
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         enable_q <= event_flag_pkg::ENABLE_RESET;
      end else if (reg_write) begin
         if (hit(reg_addr, event_flag_pkg::ALERT_ENABLE_LOW_OFS)) begin
            enable_q[7:0] <= reg_wdata;
         end
         if (hit(reg_addr, event_flag_pkg::ALERT_ENABLE_HIGH_OFS)) begin
            enable_q[9:8] <= reg_wdata[1:0];
         end
      end
   end

   // ************************************************************
   // Read data, unused and reserved bits read zero
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdata_q <= event_flag_pkg::RDATA_RESET;
      end else if (reg_read) begin
         unique case (reg_addr)
            event_flag_pkg::ALERT_ENABLE_LOW_OFS: begin
               rdata_q <= enable_q[7:0];
            end
            event_flag_pkg::ALERT_ENABLE_HIGH_OFS: begin
               rdata_q <= {6'h00, enable_q[9:8]};
            end
            event_flag_pkg::EVENT_STATUS_LOW_OFS: begin
               rdata_q <= status[7:0];
            end
            event_flag_pkg::EVENT_STATUS_HIGH_OFS: begin
               rdata_q <= {6'h00, status[9:8]};
            end
            default: begin
               rdata_q <= 8'h00;
            end
         endcase
      end
   end

   assign reg_rdata = rdata_q;

   // ************************************************************
   // Open-drain alert: level is always low, only the enable moves
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         irq_oe_q <= 1'b0;
         irq_o_q <= 1'b0;
      end else begin
         irq_oe_q <= |(enable_q & latched);
         irq_o_q <= 1'b0;
      end
   end

   assign irq_pin_oe = irq_oe_q;
   assign irq_pin_o = irq_o_q;

   // ************************************************************
   // Assertions
   // ************************************************************
   // Named terms keep $past on plain signals
   assign armed = rise & enable_q;
   assign pending = enable_q & latched;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   never_high_a: assert property (irq_pin_o == 1'b0)
      else $error("alert pin driven high");

   alert_level_a: assert property (
      pending != 10'h000 |=> irq_pin_oe)
      else $error("alert enable does not follow pending flags");

   alert_release_a: assert property (
      pending == 10'h000 |=> !irq_pin_oe)
      else $error("alert held with no pending flag");

   latch_set_a: assert property (
      armed != 10'h000 && !soft_reset |=>
      (latched & $past(armed)) == $past(armed))
      else $error("enabled edge not latched");

   // A write in the edge cycle may turn the enable off, so it is excluded
   latch_irq_a: assert property (
      armed != 10'h000 && !soft_reset && !reg_write ##1 !reg_write |=>
      irq_pin_oe)
      else $error("latched event did not raise alert");

   write_clear_a: assert property (
      reg_write && reg_addr == event_flag_pkg::EVENT_STATUS_LOW_OFS &&
      reg_wdata[0] && !(rise[0] && enable_q[0]) |=> !latched[0])
      else $error("write one did not clear flag");

   soft_clear_a: assert property (
      soft_reset |=> latched == 10'h000)
      else $error("software reset left a latched flag");

   live_read_a: assert property (
      reg_read && reg_addr == event_flag_pkg::EVENT_STATUS_LOW_OFS &&
      !enable_q[0] |=> reg_rdata[0] == $past(live[0]))
      else $error("disabled flag does not read live source");

   disabled_quiet_a: assert property (
      enable_q == 10'h000 |=> !irq_pin_oe)
      else $error("alert with all flags disabled");

   enable_store_a: assert property (
      reg_write && reg_addr == event_flag_pkg::ALERT_ENABLE_LOW_OFS |=>
      enable_q[7:0] == $past(reg_wdata))
      else $error("enable write not stored");

   high_reserved_a: assert property (
      reg_read && reg_addr == event_flag_pkg::EVENT_STATUS_HIGH_OFS |=>
      reg_rdata[7:2] == 6'h00)
      else $error("reserved status bits not zero");

   high_live_a: assert property (
      reg_read && reg_addr == event_flag_pkg::EVENT_STATUS_HIGH_OFS &&
      !enable_q[9] |=> reg_rdata[1] == $past(live[9]))
      else $error("disabled high flag does not read live source");

   high_clear_a: assert property (
      reg_write && reg_addr == event_flag_pkg::EVENT_STATUS_HIGH_OFS &&
      reg_wdata[1] && !armed[9] |=> !latched[9])
      else $error("write one did not clear high flag");

   set_wins_a: assert property (
      armed[0] && clear[0] && !soft_reset |=> latched[0])
      else $error("edge lost to a clear in the same cycle");

   no_latch_off_a: assert property (
      !enable_q[1] && !latched[1] |=> !latched[1])
      else $error("disabled flag latched an edge");

   enable_high_a: assert property (
      reg_write && reg_addr == event_flag_pkg::ALERT_ENABLE_HIGH_OFS |=>
      enable_q[9:8] == $past(reg_wdata[1:0]))
      else $error("high enable write not stored");

   enable_read_a: assert property (
      reg_read && reg_addr == event_flag_pkg::ALERT_ENABLE_LOW_OFS |=>
      reg_rdata == $past(enable_q[7:0]))
      else $error("enable read does not match stored bits");

   alert_cover_c: cover property (!irq_pin_oe ##1 irq_pin_oe);
   alert_release_c: cover property (irq_pin_oe ##1 !irq_pin_oe);
   set_and_clear_c: cover property (rise[0] && enable_q[0] && clear[0]);
   hidden_latch_c: cover property (!enable_q[2] && latched[2]);
   live_read_c: cover property (reg_read && !enable_q[9] &&
      reg_addr == event_flag_pkg::EVENT_STATUS_HIGH_OFS);
endmodule : event_flag_interrupt_unit
`default_nettype wire

// *** rtl/event_flag_pkg.sv ***
// Constants shared by the event flag interrupt unit
package event_flag_pkg;
   // ************************************************************
   // Sizes
   // ************************************************************
   localparam int FLAG_COUNT = 10;
   localparam int ADDR_WIDTH = 8;
   localparam int DATA_WIDTH = 8;
   localparam int HIGH_FLAGS = FLAG_COUNT - DATA_WIDTH;
   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [7:0] ALERT_ENABLE_LOW_OFS = 8'h04;
   localparam logic [7:0] ALERT_ENABLE_HIGH_OFS = 8'h05;
   localparam logic [7:0] EVENT_STATUS_LOW_OFS = 8'h06;
   localparam logic [7:0] EVENT_STATUS_HIGH_OFS = 8'h07;
   // ************************************************************
   // Values after reset
   // ************************************************************
   localparam logic [9:0] ENABLE_RESET = 10'h000;
   localparam logic [7:0] RDATA_RESET = 8'h00;
   localparam logic SYNC_RESET = 1'b0;
endpackage : event_flag_pkg

// *** rtl/event_flag_cell.sv ***
// One event flag: source synchroniser, rising edge and latch
`timescale 1ns/10ps
`default_nettype none
module event_flag_cell (
   input wire logic sys_clk, // System clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic source, // Raw event source, other domain
   input wire logic enable, // Alert enable bit for this flag
   input wire logic clear, // Write-one clear of the latch
   input wire logic soft_reset, // Software reset pulse
   output logic live, // Synchronised live source level
   output logic rise, // Rising edge of the live source
   output logic latched // Latched event
);
   logic meta_q;
   logic live_q;
   logic prev_q;
   logic latch_q;

   // ************************************************************
   // Synchroniser and edge detector
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         meta_q <= event_flag_pkg::SYNC_RESET;
         live_q <= event_flag_pkg::SYNC_RESET;
         prev_q <= event_flag_pkg::SYNC_RESET;
      end else begin
         meta_q <= source;
         live_q <= meta_q;
         prev_q <= live_q;
      end
   end

   assign live = live_q;
   assign rise = live_q & ~prev_q;
   assign latched = latch_q;

   // ************************************************************
   // Latch: an edge in the clearing cycle still wins
   // ************************************************************
   always_ff @(posedge sys_clk) begin
      if (!rst_n || soft_reset) begin
         latch_q <= 1'b0;
      end else if (enable && rise) begin
         latch_q <= 1'b1;
      end else if (clear) begin
         latch_q <= 1'b0;
      end
   end
endmodule : event_flag_cell
`default_nettype wire

// *** verification/host_model.sv ***
// Host model: register accesses and the pulled-up alert line
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input wire logic sys_clk, // System clock
   input wire logic irq_pin_o, // Alert pin level
   input wire logic irq_pin_oe, // Alert pin enable
   input wire logic [7:0] reg_rdata, // Read data
   output logic reg_write, // Write strobe
   output logic reg_read, // Read strobe
   output logic [7:0] reg_addr, // Offset
   output logic [7:0] reg_wdata, // Write data
   output logic irq_n // Wired line, pulled up
);
   // Pull-up wins unless a device sinks the line
   assign irq_n = irq_pin_oe ? irq_pin_o : 1'b1;
   initial begin
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 8'hFF;
      reg_wdata = 8'h00;
   end
   task write_reg(input logic [7:0] ofs, input logic [7:0] d);
      @(posedge sys_clk);
      reg_write <= 1'b1;
      reg_addr <= ofs;
      reg_wdata <= d;
      @(posedge sys_clk);
      // Idle bus shows inverted values so stale data is never trusted
      reg_write <= 1'b0;
      reg_addr <= ~ofs;
      reg_wdata <= ~d;
   endtask : write_reg
   task read_reg(input logic [7:0] ofs, output logic [7:0] d);
      @(posedge sys_clk);
      reg_read <= 1'b1;
      reg_addr <= ofs;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      reg_addr <= ~ofs;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask : read_reg
   task service(input logic [7:0] ofs, input logic [7:0] m,
                output logic [7:0] st);
      read_reg(ofs, st);
      write_reg(ofs - 8'h02, 8'h00);
      read_reg(ofs, st);
      write_reg(ofs, m);
      write_reg(ofs - 8'h02, m);
   endtask : service
endmodule : host_model
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the event flag interrupt unit
`timescale 1ns/10ps
`default_nettype none
module tb;
   typedef struct packed {
      logic [9:0] en;
      logic [9:0] src;
      logic [9:0] st;
      logic irq;
   } row_type;
   localparam logic [7:0] ENL = event_flag_pkg::ALERT_ENABLE_LOW_OFS;
   localparam logic [7:0] ENH = event_flag_pkg::ALERT_ENABLE_HIGH_OFS;
   localparam logic [7:0] STL = event_flag_pkg::EVENT_STATUS_LOW_OFS;
   localparam logic [7:0] STH = event_flag_pkg::EVENT_STATUS_HIGH_OFS;
   // Enables, sources, expected status, expected line level
   row_type rows [5] = '{'{10'h000, 10'h3FF, 10'h3FF, 1'b1},
      '{10'h3FF, 10'h3FF, 10'h3FF, 1'b0}, '{10'h001, 10'h200, 10'h200, 1'b1},
      '{10'h200, 10'h201, 10'h201, 1'b0}, '{10'h3FF, 10'h000, 10'h000, 1'b1}};
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic soft_reset = 1'b0;
   logic [9:0] event_source = 10'h000;
   logic reg_write, reg_read, irq_pin_o, irq_pin_oe, irq_n;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, b;
   logic [9:0] v;
   int errors = 0;
   int checks = 0;
   always #12.5 sys_clk = ~sys_clk;
   event_flag_interrupt_unit event_flag_interrupt_unit_i (.sys_clk(sys_clk),
      .rst_n(rst_n), .soft_reset(soft_reset), .event_source(event_source),
      .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_pin_o(irq_pin_o),
      .irq_pin_oe(irq_pin_oe));
   host_model host_model_i (.sys_clk(sys_clk), .irq_pin_o(irq_pin_o),
      .irq_pin_oe(irq_pin_oe), .reg_rdata(reg_rdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .irq_n(irq_n));
   task check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task tally_and_finish();
      if (errors == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc
   // Sampled half a cycle after the edge so the design's update has landed
   task line1(input logic exp);
      @(negedge sys_clk);
      check("alert line", {9'h000, irq_n}, {9'h000, exp});
      check("pin level", {9'h000, irq_pin_o}, 10'h000);
   endtask : line1
   task wr10(input logic [7:0] ofs, input logic [9:0] d);
      host_model_i.write_reg(ofs, d[7:0]);
      host_model_i.write_reg(ofs + 8'h01, {6'h00, d[9:8]});
   endtask : wr10
   task rd10(output logic [9:0] d);
      logic [7:0] lo;
      logic [7:0] hi;
      host_model_i.read_reg(STL, lo);
      host_model_i.read_reg(STH, hi);
      d = {hi[1:0], lo};
   endtask : rd10
   task src(input logic [9:0] s);
      @(posedge sys_clk);
      event_source <= s;
   endtask : src
   task fresh(input logic [9:0] en);
      src(10'h000);
      cyc(4);
      wr10(STL, 10'h3FF);
      wr10(ENL, en);
   endtask : fresh
   initial begin
      #200000;
      errors++;
      tally_and_finish();
   end
   initial begin
      cyc(4);
      line1(1'b1);
      check("rdata", {2'b00, reg_rdata}, 10'h000);
      @(posedge sys_clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         fresh(rows[i].en);
         src(rows[i].src);
         cyc(6);
         rd10(v);
         check("status", v, rows[i].st);
         line1(rows[i].irq);
      end
      // One cleared flag must not release the line while another holds
      fresh(10'h003);
      src(10'h003);
      cyc(6);
      wr10(STL, 10'h001);
      line1(1'b0);
      rd10(v);
      check("status", v, 10'h002);
      wr10(STL, 10'h002);
      cyc(2);
      line1(1'b1);
      // A disabled latch is hidden, shows again, then soft reset clears it
      fresh(10'h004);
      src(10'h004);
      cyc(6);
      wr10(ENL, 10'h000);
      cyc(2);
      line1(1'b1);
      rd10(v);
      check("hidden status", v, 10'h004);
      wr10(ENL, 10'h004);
      cyc(2);
      line1(1'b0);
      @(posedge sys_clk);
      soft_reset <= 1'b1;
      @(posedge sys_clk);
      soft_reset <= 1'b0;
      cyc(2);
      line1(1'b1);
      src(10'h000);
      cyc(4);
      src(10'h004);
      cyc(6);
      line1(1'b0);
      // Drop the source first: the synchroniser restarts at zero
      src(10'h000);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      cyc(5);
      rst_n <= 1'b1;
      wr10(ENL, 10'h004);
      cyc(2);
      line1(1'b1);
      rd10(v);
      check("status after reset", v, 10'h000);
      fresh(10'h200);
      src(10'h200);
      cyc(4);
      src(10'h000);
      cyc(4);
      line1(1'b0);
      host_model_i.service(STH, 8'h02, b);
      check("recheck", {2'b00, b}, 10'h000);
      cyc(2);
      line1(1'b1);
      host_model_i.write_reg(ENH, 8'hFF);
      host_model_i.read_reg(ENH, b);
      check("enable high", {2'b00, b}, 10'h003);
      host_model_i.read_reg(8'h08, b);
      check("unmapped", {2'b00, b}, 10'h000);
      host_model_i.write_reg(ENL, 8'hA5);
      host_model_i.read_reg(ENL, b);
      check("enable low", {2'b00, b}, 10'h0A5);
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
